// ---- logic/thermal_sleep_pkg.sv ----
// Constants, types and register map for the thermal fault and sleep controller
//
// Contract
// - Warning trip sets warning and thermal flags
// - Warning flags clear alone below hysteresis
// - Report select routes warning to fault pin
// - Shutdown trip disables drivers, latches fault flags
// - Latched mode recovers by pulse or clear
// - Auto mode recovers drivers; flags stay latched
// - Sleep pin low disables power stages, logic
// - Sleep entered only after entry delay
// - Sleep pin high wakes device automatically
// - Short sleep pin pulse clears latched faults
`default_nettype none
package thermal_sleep_pkg;
   // Clock
   localparam int unsigned CLK_PERIOD_NS = 100;
   // Times in their own unit
   localparam int unsigned RST_PULSE_MIN_US = 20;
   localparam int unsigned RST_PULSE_MAX_US = 40;
   localparam int unsigned SLEEP_ENTRY_US = 120;
   localparam int unsigned WAKE_US = 1000;
   // Cycle counts: least times round up, longest times round down
   localparam int unsigned RST_MIN_CYC = (RST_PULSE_MIN_US * 1000 + CLK_PERIOD_NS - 1)
                                         / CLK_PERIOD_NS;
   localparam int unsigned RST_MAX_CYC = (RST_PULSE_MAX_US * 1000) / CLK_PERIOD_NS;
   localparam int unsigned SLEEP_CYC = (SLEEP_ENTRY_US * 1000 + CLK_PERIOD_NS - 1)
                                       / CLK_PERIOD_NS;
   localparam int unsigned WAKE_CYC_DEFAULT = (WAKE_US * 1000 + CLK_PERIOD_NS - 1)
                                              / CLK_PERIOD_NS;
   localparam int unsigned CNT_W = 16;
   // Register bus
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_INT_STAT = 4'h8;
   localparam logic [ADDR_W-1:0] ADDR_INT_MASK = 4'hC;
   // Control fields
   localparam int unsigned CTRL_REPORT_BIT = 0;
   localparam int unsigned CTRL_RECOVERY_BIT = 1;
   localparam int unsigned CTRL_CLEAR_BIT = 2;
   localparam logic CTRL_REPORT_RST = 1'h0;
   localparam logic CTRL_RECOVERY_RST = 1'h0;
   // Status fields
   localparam int unsigned ST_WARN_BIT = 0;
   localparam int unsigned ST_THERMAL_BIT = 1;
   localparam int unsigned ST_SHUTDOWN_BIT = 2;
   localparam int unsigned ST_FAULT_BIT = 3;
   localparam int unsigned ST_SD_ACTIVE_BIT = 4;
   localparam int unsigned ST_SLEEP_BIT = 5;
   localparam int unsigned ST_READY_BIT = 6;
   // Interrupt events
   localparam int unsigned EV_W = 5;
   localparam int unsigned EV_WARN = 0;
   localparam int unsigned EV_SHUTDOWN = 1;
   localparam int unsigned EV_SLEEP = 2;
   localparam int unsigned EV_WAKE = 3;
   localparam int unsigned EV_PULSE = 4;
   localparam logic [EV_W-1:0] EV_RST = 5'h00;
   localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   // Power state
   typedef enum logic [3:0] {
      PS_ACTIVE = 4'h1,
      PS_LOW = 4'h2,
      PS_SLEEP = 4'h4,
      PS_WAKE = 4'h8
   } power_state_t;
endpackage
`default_nettype wire

// ---- logic/sync2.sv ----
// Two flip-flop synchroniser for asynchronous inputs
`default_nettype none
module sync2 #(
   parameter int unsigned WIDTH = 1
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic nrst_in,
   // Data
   input wire logic [WIDTH-1:0] d_in,
   output logic [WIDTH-1:0] q_out
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] q_r;

   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         meta_r <= '0;
         q_r <= '0;
      end else begin
         meta_r <= d_in;
         q_r <= meta_r;
      end
   end

   assign q_out = q_r;
endmodule
`default_nettype wire

// ---- logic/thermal_fault_and_sleep_control.sv ----
// Thermal fault handling and sleep pin power-state control
//
// The placing of the registers and strobed register access were chosen for this implementation.
`default_nettype none
module thermal_fault_and_sleep_control
   import thermal_sleep_pkg::*;
#(
   parameter int unsigned WAKE_CYCLES = WAKE_CYC_DEFAULT
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic nrst_in,
   // Pins and comparators
   input wire logic sleep_pin_n_in,
   input wire logic temp_warn_trip_in,
   input wire logic temp_shutdown_trip_in,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr_in,
   input wire logic [DATA_W-1:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [DATA_W-1:0] reg_rdata_out,
   // Interrupt
   output logic irq_out,
   // Fault pin, open drain
   output logic fault_out_n_out,
   output logic fault_oe_out,
   // Power stage controls
   output logic bridge_enable_out,
   output logic charge_pump_enable_out,
   output logic logic_regulator_enable_out,
   output logic serial_enable_out,
   output logic sleep_out,
   output logic inputs_ready_out
);
   // Synchronised inputs; the pin is inverted so a cleared synchroniser reads awake
   logic sleep_req_s;
   wire logic sleep_pin_s = !sleep_req_s;
   logic warn_s;
   logic sd_s;

   sync2 #(
      .WIDTH(3)
   ) u_sync (
      .core_clk_in(core_clk_in),
      .nrst_in(nrst_in),
      .d_in({~sleep_pin_n_in, temp_warn_trip_in, temp_shutdown_trip_in}),
      .q_out({sleep_req_s, warn_s, sd_s})
   );

   // Power state machine
   power_state_t state_r;
   power_state_t state_nxt;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic pulse_clear;
   logic ev_sleep;
   logic ev_wake;

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      pulse_clear = 1'b0;
      ev_sleep = 1'b0;
      ev_wake = 1'b0;
      unique case (state_r)
         PS_ACTIVE: begin
            if (!sleep_pin_s) begin
               state_nxt = PS_LOW;
               cnt_nxt = CNT_ZERO;
            end
         end
         PS_LOW: begin
            if (sleep_pin_s) begin
               state_nxt = PS_ACTIVE;
               if (cnt_r >= CNT_W'(RST_MIN_CYC)) begin
                  pulse_clear = 1'b1;
               end
            end else if (cnt_r >= CNT_W'(SLEEP_CYC - 1)) begin
               state_nxt = PS_SLEEP;
               ev_sleep = 1'b1;
            end else begin
               cnt_nxt = cnt_r + CNT_ONE;
            end
         end
         PS_SLEEP: begin
            if (sleep_pin_s) begin
               state_nxt = PS_WAKE;
               cnt_nxt = CNT_ZERO;
            end
         end
         PS_WAKE: begin
            if (!sleep_pin_s) begin
               state_nxt = PS_LOW;
               cnt_nxt = CNT_ZERO;
            end else if (cnt_r >= CNT_W'(WAKE_CYCLES - 1)) begin
               state_nxt = PS_ACTIVE;
               ev_wake = 1'b1;
            end else begin
               cnt_nxt = cnt_r + CNT_ONE;
            end
         end
         default: begin
            state_nxt = PS_WAKE;
            cnt_nxt = CNT_ZERO;
         end
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         state_r <= PS_WAKE;
         cnt_r <= CNT_ZERO;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Register writes, taken only in the active power state
   logic report_sel_r;
   logic report_sel_nxt;
   logic recovery_sel_r;
   logic recovery_sel_nxt;
   logic [EV_W-1:0] int_mask_r;
   logic [EV_W-1:0] int_mask_nxt;
   logic wr_ok;
   logic clear_cmd;

   always_comb begin
      wr_ok = reg_wr_in && (state_r == PS_ACTIVE);
      report_sel_nxt = report_sel_r;
      recovery_sel_nxt = recovery_sel_r;
      int_mask_nxt = int_mask_r;
      clear_cmd = pulse_clear;
      if (wr_ok && reg_addr_in == ADDR_CTRL) begin
         report_sel_nxt = reg_wdata_in[CTRL_REPORT_BIT];
         recovery_sel_nxt = reg_wdata_in[CTRL_RECOVERY_BIT];
         clear_cmd = pulse_clear || reg_wdata_in[CTRL_CLEAR_BIT];
      end
      if (wr_ok && reg_addr_in == ADDR_INT_MASK) begin
         int_mask_nxt = reg_wdata_in[EV_W-1:0];
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         report_sel_r <= CTRL_REPORT_RST;
         recovery_sel_r <= CTRL_RECOVERY_RST;
         int_mask_r <= EV_RST;
      end else begin
         report_sel_r <= report_sel_nxt;
         recovery_sel_r <= recovery_sel_nxt;
         int_mask_r <= int_mask_nxt;
      end
   end

   // Thermal flags and shutdown control
   logic warn_flag_r;
   logic warn_flag_nxt;
   logic thermal_flag_r;
   logic thermal_flag_nxt;
   logic shutdown_flag_r;
   logic shutdown_flag_nxt;
   logic fault_flag_r;
   logic fault_flag_nxt;
   logic sd_active_r;
   logic sd_active_nxt;
   logic logic_on;
   logic ev_warn;
   logic ev_shutdown;

   always_comb begin
      logic_on = (state_r != PS_SLEEP);
      // Warning follows the comparator, no clear needed
      warn_flag_nxt = warn_s && logic_on;
      // Shutdown flags latch; a trip in the clear cycle wins
      if (!logic_on) begin
         shutdown_flag_nxt = 1'b0;
      end else begin
         shutdown_flag_nxt = sd_s || (shutdown_flag_r && !clear_cmd);
      end
      // Driver shutdown state
      if (!logic_on) begin
         sd_active_nxt = 1'b0;
      end else if (sd_s) begin
         sd_active_nxt = 1'b1;
      end else if (recovery_sel_r) begin
         sd_active_nxt = 1'b0;
      end else if (clear_cmd) begin
         sd_active_nxt = 1'b0;
      end else begin
         sd_active_nxt = sd_active_r;
      end
      thermal_flag_nxt = warn_flag_nxt || shutdown_flag_nxt;
      fault_flag_nxt = shutdown_flag_nxt || (warn_flag_nxt && report_sel_r);
      ev_warn = warn_flag_nxt && !warn_flag_r;
      ev_shutdown = sd_s && logic_on && !sd_active_r;
   end

   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         warn_flag_r <= 1'b0;
         thermal_flag_r <= 1'b0;
         shutdown_flag_r <= 1'b0;
         fault_flag_r <= 1'b0;
         sd_active_r <= 1'b0;
      end else begin
         warn_flag_r <= warn_flag_nxt;
         thermal_flag_r <= thermal_flag_nxt;
         shutdown_flag_r <= shutdown_flag_nxt;
         fault_flag_r <= fault_flag_nxt;
         sd_active_r <= sd_active_nxt;
      end
   end

   // Pin and power stage outputs
   logic fault_oe_r;
   logic fault_oe_nxt;
   logic bridge_en_r;
   logic bridge_en_nxt;
   logic cp_en_r;
   logic cp_en_nxt;
   logic reg_en_r;
   logic reg_en_nxt;
   logic ready_r;
   logic ready_nxt;
   logic sleep_r;
   logic sleep_nxt;
   logic awake_nxt;

   always_comb begin
      awake_nxt = (state_nxt == PS_ACTIVE) || (state_nxt == PS_LOW);
      fault_oe_nxt = sd_active_nxt || (warn_flag_nxt && report_sel_r);
      bridge_en_nxt = awake_nxt && !sd_active_nxt;
      cp_en_nxt = (state_nxt != PS_SLEEP) && !sd_active_nxt;
      reg_en_nxt = (state_nxt != PS_SLEEP);
      ready_nxt = awake_nxt;
      sleep_nxt = (state_nxt == PS_SLEEP);
   end

   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         fault_oe_r <= 1'b0;
         bridge_en_r <= 1'b0;
         cp_en_r <= 1'b0;
         reg_en_r <= 1'b0;
         ready_r <= 1'b0;
         sleep_r <= 1'b0;
      end else begin
         fault_oe_r <= fault_oe_nxt;
         bridge_en_r <= bridge_en_nxt;
         cp_en_r <= cp_en_nxt;
         reg_en_r <= reg_en_nxt;
         ready_r <= ready_nxt;
         sleep_r <= sleep_nxt;
      end
   end

   // Interrupt status, read clears, set wins
   logic [EV_W-1:0] int_stat_r;
   logic [EV_W-1:0] int_stat_nxt;
   logic [EV_W-1:0] events;
   logic irq_r;
   logic irq_nxt;

   always_comb begin
      events = EV_RST;
      events[EV_WARN] = ev_warn;
      events[EV_SHUTDOWN] = ev_shutdown;
      events[EV_SLEEP] = ev_sleep;
      events[EV_WAKE] = ev_wake;
      events[EV_PULSE] = pulse_clear;
      int_stat_nxt = int_stat_r;
      if (reg_rd_in && reg_addr_in == ADDR_INT_STAT) begin
         int_stat_nxt = EV_RST;
      end
      int_stat_nxt = int_stat_nxt | events;
      irq_nxt = |(int_stat_nxt & int_mask_nxt);
   end

   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         int_stat_r <= EV_RST;
         irq_r <= 1'b0;
      end else begin
         int_stat_r <= int_stat_nxt;
         irq_r <= irq_nxt;
      end
   end

   // Read data, valid the cycle after the strobe
   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] rdata_nxt;
   logic [DATA_W-1:0] status_word;
   logic [DATA_W-1:0] ctrl_word;

   always_comb begin
      status_word = DATA_ZERO;
      status_word[ST_WARN_BIT] = warn_flag_r;
      status_word[ST_THERMAL_BIT] = thermal_flag_r;
      status_word[ST_SHUTDOWN_BIT] = shutdown_flag_r;
      status_word[ST_FAULT_BIT] = fault_flag_r;
      status_word[ST_SD_ACTIVE_BIT] = sd_active_r;
      status_word[ST_SLEEP_BIT] = sleep_r;
      status_word[ST_READY_BIT] = ready_r;
      ctrl_word = DATA_ZERO;
      ctrl_word[CTRL_REPORT_BIT] = report_sel_r;
      ctrl_word[CTRL_RECOVERY_BIT] = recovery_sel_r;
      rdata_nxt = DATA_ZERO;
      if (reg_rd_in) begin
         unique case (reg_addr_in)
            ADDR_CTRL: rdata_nxt = ctrl_word;
            ADDR_STATUS: rdata_nxt = status_word;
            ADDR_INT_STAT: rdata_nxt = {{(DATA_W - EV_W){1'b0}}, int_stat_r};
            ADDR_INT_MASK: rdata_nxt = {{(DATA_W - EV_W){1'b0}}, int_mask_r};
            default: rdata_nxt = DATA_ZERO;
         endcase
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         rdata_r <= DATA_ZERO;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // Output drive
   assign reg_rdata_out = rdata_r;
   assign irq_out = irq_r;
   assign fault_out_n_out = 1'b0;
   assign fault_oe_out = fault_oe_r;
   assign bridge_enable_out = bridge_en_r;
   assign charge_pump_enable_out = cp_en_r;
   assign logic_regulator_enable_out = reg_en_r;
   assign serial_enable_out = ready_r;
   assign sleep_out = sleep_r;
   assign inputs_ready_out = ready_r;
endmodule
`default_nettype wire

// ---- tb/thermal_sleep_properties.sv ----
// Assertion checker for the thermal fault and sleep controller
`default_nettype none
module thermal_sleep_properties
   import thermal_sleep_pkg::*;
#(
   parameter int unsigned WAKE_CYCLES = WAKE_CYC_DEFAULT
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic nrst_in,
   // Watched inputs
   input wire logic sleep_pin_n_in,
   input wire logic temp_shutdown_trip_in,
   input wire logic reg_rd_in,
   // Watched outputs
   input wire logic [DATA_W-1:0] reg_rdata_out,
   input wire logic fault_out_n_out,
   input wire logic fault_oe_out,
   input wire logic bridge_enable_out,
   input wire logic charge_pump_enable_out,
   input wire logic logic_regulator_enable_out,
   input wire logic serial_enable_out,
   input wire logic sleep_out,
   input wire logic inputs_ready_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!nrst_in);
   // Cycles the sleep pin has stayed low or high
   logic [CNT_W-1:0] low_r, low_nxt, high_r, high_nxt;
   always_comb begin
      low_nxt = sleep_pin_n_in ? CNT_ZERO : ((&low_r) ? low_r : low_r + CNT_ONE);
      high_nxt = !sleep_pin_n_in ? CNT_ZERO : ((&high_r) ? high_r : high_r + CNT_ONE);
   end
   always_ff @(posedge core_clk_in) begin
      low_r <= nrst_in ? low_nxt : CNT_ZERO;
      high_r <= nrst_in ? high_nxt : CNT_ZERO;
   end
   chk_fault_data_low: assert property (fault_out_n_out == 1'b0)
      else $error("fault pin data not low");
   chk_sleep_power_off: assert property (sleep_out |-> !bridge_enable_out &&
      !charge_pump_enable_out && !logic_regulator_enable_out && !serial_enable_out)
      else $error("stage enabled while asleep");
   chk_shutdown_stops_drive: assert property ((temp_shutdown_trip_in [*5] ##0
      inputs_ready_out) |-> !bridge_enable_out && !charge_pump_enable_out && fault_oe_out)
      else $error("shutdown trip did not stop drivers");
   chk_sleep_not_early: assert property ($rose(sleep_out) |-> low_r >= SLEEP_CYC)
      else $error("sleep entered before entry delay");
   chk_sleep_on_time: assert property (low_r >= SLEEP_CYC + 8 |-> sleep_out)
      else $error("sleep not entered after long low");
   chk_wake_leaves_sleep: assert property (sleep_pin_n_in [*6] |-> !sleep_out)
      else $error("still asleep with pin high");
   chk_ready_not_early: assert property ($rose(inputs_ready_out) |-> high_r >= WAKE_CYCLES)
      else $error("inputs ready before wake time");
   chk_read_data_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == DATA_ZERO)
      else $error("read data outside read slot");
   cover property ($rose(sleep_out));
   cover property ($fell(sleep_out));
   cover property ($rose(fault_oe_out));
endmodule
bind thermal_fault_and_sleep_control thermal_sleep_properties #(.WAKE_CYCLES(WAKE_CYCLES))
   thermal_sleep_properties_i (.core_clk_in, .nrst_in, .sleep_pin_n_in,
   .temp_shutdown_trip_in, .reg_rd_in, .reg_rdata_out, .fault_out_n_out, .fault_oe_out,
   .bridge_enable_out, .charge_pump_enable_out, .logic_regulator_enable_out,
   .serial_enable_out, .sleep_out, .inputs_ready_out);
`default_nettype wire

// ---- tb/controller_model.sv ----
// Outside controller: drives the sleep pin and watches the fault line
`default_nettype none
module controller_model #(
   parameter int unsigned WAKE_WAIT = 16
) (
   // Clock
   input wire logic core_clk_in,
   // Fault pin
   input wire logic fault_oe_in,
   output logic fault_line_out,
   // Sleep pin
   output logic sleep_pin_n_out
);
   timeunit 1ns;
   timeprecision 1ns;
   initial sleep_pin_n_out = 1'b1;
   // Pull-up holds the line high when released
   assign fault_line_out = fault_oe_in ? 1'b0 : 1'b1;
   task automatic reset_pulse(input int unsigned n);
      @(posedge core_clk_in);
      sleep_pin_n_out <= 1'b0;
      repeat (n) @(posedge core_clk_in);
      sleep_pin_n_out <= 1'b1;
   endtask
   task automatic go_sleep();
      @(posedge core_clk_in);
      sleep_pin_n_out <= 1'b0;
   endtask
   // Keeps quiet for WAKE_WAIT cycles after raising the pin
   task automatic wake();
      @(posedge core_clk_in);
      sleep_pin_n_out <= 1'b1;
      repeat (WAKE_WAIT) @(posedge core_clk_in);
   endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Testbench for the thermal fault and sleep controller
`default_nettype none
module testbench
   import thermal_sleep_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int WAKE = 20;
   logic clk = 0, rst_n = 0, warn = 0, sd = 0, wr = 0, rd = 0;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0, rdata, d;
   logic irq, f_n, f_oe, br, cp, lreg, ser, slp, rdy, pin_n, line;
   int fails = 0, checks_done = 0, cyc = 0, n;
   thermal_fault_and_sleep_control #(.WAKE_CYCLES(WAKE)) thermal_fault_and_sleep_control_i (
      .core_clk_in(clk), .nrst_in(rst_n), .sleep_pin_n_in(pin_n), .temp_warn_trip_in(warn),
      .temp_shutdown_trip_in(sd), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
      .reg_rd_in(rd), .reg_rdata_out(rdata), .irq_out(irq), .fault_out_n_out(f_n),
      .fault_oe_out(f_oe), .bridge_enable_out(br), .charge_pump_enable_out(cp),
      .logic_regulator_enable_out(lreg), .serial_enable_out(ser), .sleep_out(slp),
      .inputs_ready_out(rdy));
   controller_model #(.WAKE_WAIT(WAKE - 4)) controller_model_i (.core_clk_in(clk),
      .fault_oe_in(f_oe), .fault_line_out(line), .sleep_pin_n_out(pin_n));
   initial forever #50 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         fails++;
         final_report();
      end
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic wait_cyc(input int c);
      repeat (c) @(posedge clk);
      #10;
   endtask
   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #10 v = rdata;
   endtask
   task automatic chk_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      logic [DATA_W-1:0] v;
      rd_reg(a, v);
      checks_done++;
      if (v !== e) begin
         fails++;
         $display("mismatch at %0t: reg %h read %h expected %h", $time, a, v, e);
      end
   endtask
   // Pins: irq, sleep, fault line low, bridge, pump, ready
   // Regulator is expected on unless asleep, serial port on when ready
   task automatic chk_pins(input logic [7:0] e);
      logic [7:0] p;
      logic [7:0] ee;
      p = {lreg, ser, irq, slp, ~line, br, cp, rdy};
      ee = {~e[4], e[0], e[5:0]};
      checks_done++;
      if (p !== ee) begin
         fails++;
         $display("mismatch at %0t: pins %h expected %h", $time, p, ee);
      end
   endtask
   task automatic trip(input logic w, input logic s);
      @(posedge clk);
      warn <= w;
      sd <= s;
      wait_cyc(6);
   endtask
   task automatic wait_ready();
      for (n = 0; n < WAKE + 40 && rdy !== 1'b1; n++) @(posedge clk);
      #10;
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      wait_ready();
      rd_reg(ADDR_INT_STAT, d);
      chk_reg(ADDR_STATUS, 8'h40);
      chk_pins(8'h07);
      $display("test reset done");
      trip(1'b1, 1'b0);
      chk_reg(ADDR_STATUS, 8'h43);
      chk_pins(8'h07);
      wr_reg(ADDR_CTRL, 8'h01);
      wait_cyc(4);
      chk_pins(8'h0F);
      chk_reg(ADDR_STATUS, 8'h4B);
      trip(1'b0, 1'b0);
      chk_reg(ADDR_STATUS, 8'h40);
      chk_pins(8'h07);
      $display("test warning done");
      chk_reg(ADDR_INT_STAT, 8'h01);
      wr_reg(ADDR_INT_MASK, 8'h02);
      wr_reg(ADDR_CTRL, 8'h00);
      trip(1'b0, 1'b1);
      chk_pins(8'h29);
      chk_reg(ADDR_STATUS, 8'h5E);
      chk_reg(ADDR_INT_STAT, 8'h02);
      trip(1'b0, 1'b0);
      chk_pins(8'h09);
      chk_reg(ADDR_STATUS, 8'h5E);
      wr_reg(ADDR_CTRL, 8'h04);
      wait_cyc(4);
      chk_pins(8'h07);
      chk_reg(ADDR_STATUS, 8'h40);
      chk_reg(ADDR_CTRL, 8'h00);
      chk_reg(4'h2, 8'h00);
      $display("test latched shutdown done");
      wr_reg(ADDR_CTRL, 8'h02);
      trip(1'b0, 1'b1);
      chk_pins(8'h29);
      trip(1'b0, 1'b0);
      chk_pins(8'h27);
      chk_reg(ADDR_STATUS, 8'h4E);
      controller_model_i.reset_pulse(300);
      wait_cyc(6);
      chk_reg(ADDR_STATUS, 8'h40);
      chk_reg(ADDR_INT_STAT, 8'h12);
      chk_pins(8'h07);
      $display("test recovery done");
      wr_reg(ADDR_INT_MASK, 8'h0C);
      controller_model_i.go_sleep();
      wait_cyc(1100);
      chk_pins(8'h07);
      wait_cyc(200);
      chk_pins(8'h30);
      controller_model_i.wake();
      wr_reg(ADDR_CTRL, 8'h01);
      chk_reg(ADDR_STATUS, 8'h00);
      wait_ready();
      chk_reg(ADDR_CTRL, 8'h02);
      chk_reg(ADDR_INT_STAT, 8'h0C);
      chk_pins(8'h07);
      $display("test sleep done");
      final_report();
   end
endmodule
`default_nettype wire
